// >>> acub_pkg.sv
// Package with field positions, reset values and carriers for the auxiliary control upper bits.
package acub_pkg;

  // ---------------------------------------------------------------------------
  // Coprocessor selector of the register
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ACUB_CRN = 4'h1;
  localparam logic [3:0] ACUB_CRM = 4'h0;
  localparam logic [2:0] ACUB_OPC1 = 3'h0;
  localparam logic [2:0] ACUB_OPC2 = 3'h1;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int ACUB_DI_C_POS = 31;
  localparam int ACUB_DI_B2_POS = 30;
  localparam int ACUB_DI_B1_POS = 29;
  localparam int ACUB_DI_A_POS = 28;
  localparam int ACUB_B1_CHK_POS = 27;
  localparam int ACUB_B0_CHK_POS = 26;
  localparam int ACUB_A_CHK_POS = 25;
  localparam int ACUB_SLV_EN_POS = 24;
  localparam int ACUB_SLV_USR_POS = 23;
  localparam int ACUB_LLI_OFF_POS = 22;
  localparam int ACUB_LOOP_OFF_POS = 21;
  localparam int ACUB_BHE_OFF_POS = 20;
  localparam int ACUB_FRC_OFF_POS = 19;
  localparam int ACUB_RSVD_POS = 18;

  // Bits of the check-enable configuration vector.
  localparam int ACUB_CFG_B1_BIT = 2;
  localparam int ACUB_CFG_B0_BIT = 1;
  localparam int ACUB_CFG_A_BIT = 0;

  // ---------------------------------------------------------------------------
  // Reset values of the fixed fields
  // ---------------------------------------------------------------------------
  localparam logic ACUB_OFF_RESET = 1'h0;

  // Fields held by the block, one flop each.
  typedef struct packed {
    logic dual_issue_case_c_off;
    logic dual_issue_case_b2_off;
    logic dual_issue_case_b1_off;
    logic dual_issue_case_a_off;
    logic bside_bank1_check_en;
    logic bside_bank0_check_en;
    logic aside_memory_check_en;
    logic slave_cache_ram_access_en;
    logic slave_cache_ram_user_access_en;
    logic low_latency_irq_multiple_off;
    logic loop_end_prediction_off;
    logic branch_history_ext_off;
    logic fetch_rate_ctrl_off;
  } acub_fields_t;

  // Coprocessor access request from the core.
  typedef struct packed {
    logic valid;
    logic write;
    logic privileged;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } acub_cp_req_t;

  // Answer to a coprocessor access.
  typedef struct packed {
    logic done;
    logic undef;
    logic [31:0] rdata;
  } acub_cp_rsp_t;

  // State of the module, apart from the two three-bit strap synchroniser registers.
  typedef struct packed {
    logic init_done;
    acub_fields_t fields;
    acub_cp_rsp_t rsp;
    logic cmo_undef;
    logic caches_off;
  } acub_state_t;

endpackage

// >>> acub_aux_ctrl.sv
// Upper bits of the auxiliary control register with their coprocessor access path.
`timescale 1ns/1ps
module acub_aux_ctrl
  import acub_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] check_enable_config_in,
  input wire acub_cp_req_t cp_req,
  input wire logic cmo_req,
  output acub_cp_rsp_t cp_rsp,
  output logic cmo_undef,
  output logic caches_off,
  output acub_fields_t ctrl
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  function automatic logic acub_selects(input acub_cp_req_t r);
    return r.crn == ACUB_CRN && r.crm == ACUB_CRM && r.opc1 == ACUB_OPC1 && r.opc2 == ACUB_OPC2;
  endfunction

  function automatic logic [31:0] acub_pack(input acub_fields_t f);
    logic [31:0] v;
    v = '0;
    v[ACUB_DI_C_POS] = f.dual_issue_case_c_off;
    v[ACUB_DI_B2_POS] = f.dual_issue_case_b2_off;
    v[ACUB_DI_B1_POS] = f.dual_issue_case_b1_off;
    v[ACUB_DI_A_POS] = f.dual_issue_case_a_off;
    v[ACUB_B1_CHK_POS] = f.bside_bank1_check_en;
    v[ACUB_B0_CHK_POS] = f.bside_bank0_check_en;
    v[ACUB_A_CHK_POS] = f.aside_memory_check_en;
    v[ACUB_SLV_EN_POS] = f.slave_cache_ram_access_en;
    v[ACUB_SLV_USR_POS] = f.slave_cache_ram_user_access_en;
    v[ACUB_LLI_OFF_POS] = f.low_latency_irq_multiple_off;
    v[ACUB_LOOP_OFF_POS] = f.loop_end_prediction_off;
    v[ACUB_BHE_OFF_POS] = f.branch_history_ext_off;
    v[ACUB_FRC_OFF_POS] = f.fetch_rate_ctrl_off;
    v[ACUB_RSVD_POS] = 1'h0;
    return v;
  endfunction

  function automatic acub_fields_t acub_unpack(input logic [31:0] v);
    acub_fields_t f;
    f.dual_issue_case_c_off = v[ACUB_DI_C_POS];
    f.dual_issue_case_b2_off = v[ACUB_DI_B2_POS];
    f.dual_issue_case_b1_off = v[ACUB_DI_B1_POS];
    f.dual_issue_case_a_off = v[ACUB_DI_A_POS];
    f.bside_bank1_check_en = v[ACUB_B1_CHK_POS];
    f.bside_bank0_check_en = v[ACUB_B0_CHK_POS];
    f.aside_memory_check_en = v[ACUB_A_CHK_POS];
    f.slave_cache_ram_access_en = v[ACUB_SLV_EN_POS];
    f.slave_cache_ram_user_access_en = v[ACUB_SLV_USR_POS];
    f.low_latency_irq_multiple_off = v[ACUB_LLI_OFF_POS];
    f.loop_end_prediction_off = v[ACUB_LOOP_OFF_POS];
    f.branch_history_ext_off = v[ACUB_BHE_OFF_POS];
    f.fetch_rate_ctrl_off = v[ACUB_FRC_OFF_POS];
    return f;
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration input synchroniser
  // ---------------------------------------------------------------------------
  // The strap comes from a pin, so it passes two flops before it is loaded.
  logic [2:0] cfg_meta_reg;
  logic [2:0] cfg_sync_reg;

  always_ff @(posedge clk) begin
    cfg_meta_reg <= check_enable_config_in;
    cfg_sync_reg <= cfg_meta_reg;
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  acub_state_t state_reg;
  acub_state_t state_next;
  logic hit;

  assign hit = cp_req.valid && acub_selects(cp_req);

  always_comb begin
    state_next = state_reg;
    state_next.rsp = '0;
    // The check enables load from the strap on the first cycle after reset, and only then.
    if (!state_reg.init_done) begin
      state_next.fields.bside_bank1_check_en = cfg_sync_reg[ACUB_CFG_B1_BIT];
      state_next.fields.bside_bank0_check_en = cfg_sync_reg[ACUB_CFG_B0_BIT];
      state_next.fields.aside_memory_check_en = cfg_sync_reg[ACUB_CFG_A_BIT];
      state_next.init_done = 1'h1;
    end else if (hit) begin
      state_next.rsp.done = 1'h1;
      if (!cp_req.privileged) begin
        state_next.rsp.undef = 1'h1;
      end else if (cp_req.write) begin
        // Bit 18 is dropped by the unpack.
        state_next.fields = acub_unpack(cp_req.wdata);
      end else begin
        state_next.rsp.rdata = acub_pack(state_reg.fields);
      end
    end
    state_next.cmo_undef = cmo_req && state_reg.fields.slave_cache_ram_access_en;
    state_next.caches_off = state_next.fields.slave_cache_ram_access_en;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cp_rsp = state_reg.rsp;
  assign cmo_undef = state_reg.cmo_undef;
  assign caches_off = state_reg.caches_off;
  assign ctrl = state_reg.fields;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  user_refused_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg.init_done && hit && !cp_req.privileged) |=> cp_rsp.undef && cp_rsp.done
      && $stable(ctrl))
    else $error("unprivileged access not refused");

  priv_write_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg.init_done && hit && cp_req.privileged && cp_req.write)
      |=> ctrl == acub_unpack($past(cp_req.wdata)))
    else $error("privileged write not stored");

  read_back_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg.init_done && hit && cp_req.privileged && !cp_req.write)
      |=> cp_rsp.rdata == acub_pack($past(ctrl)) && !cp_rsp.rdata[ACUB_RSVD_POS])
    else $error("read data wrong");

  wrong_sel_a: assert property (@(posedge clk) disable iff (rst)
    (cp_req.valid && !acub_selects(cp_req)) |=> !cp_rsp.done)
    else $error("other selector answered");

  cmo_undef_a: assert property (@(posedge clk) disable iff (rst)
    (cmo_req && ctrl.slave_cache_ram_access_en) |=> cmo_undef)
    else $error("maintenance not refused");

  cmo_pass_a: assert property (@(posedge clk) disable iff (rst)
    (cmo_req && !ctrl.slave_cache_ram_access_en) |=> !cmo_undef)
    else $error("maintenance refused wrongly");

  caches_off_a: assert property (@(posedge clk) disable iff (rst)
    caches_off == ctrl.slave_cache_ram_access_en)
    else $error("caches not off under slave access");

  strap_load_a: assert property (@(posedge clk) disable iff (rst)
    !state_reg.init_done |=> {ctrl.bside_bank1_check_en, ctrl.bside_bank0_check_en,
      ctrl.aside_memory_check_en} == $past(cfg_sync_reg))
    else $error("check enables not loaded from strap");

  reset_zero_a: assert property (@(posedge clk)
    $past(rst) |-> !ctrl.slave_cache_ram_access_en && !ctrl.slave_cache_ram_user_access_en
      && !ctrl.dual_issue_case_c_off && !ctrl.fetch_rate_ctrl_off)
    else $error("field not zero after reset");

  off_bits_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(hit && cp_req.write) |=> $stable({ctrl.low_latency_irq_multiple_off,
      ctrl.loop_end_prediction_off, ctrl.branch_history_ext_off, ctrl.fetch_rate_ctrl_off}))
    else $error("control bit changed without write");

  // ---------------------------------------------------------------------------
  // Field checks
  // ---------------------------------------------------------------------------
  // Each field is compared with its own bit of the written word, so a slip in
  // the unpack cannot hide behind the same function on both sides.
  logic priv_wr;
  logic priv_rd;

  assign priv_wr = state_reg.init_done && hit && cp_req.privileged && cp_req.write;
  assign priv_rd = state_reg.init_done && hit && cp_req.privileged && !cp_req.write;

  dual_issue_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> {ctrl.dual_issue_case_c_off, ctrl.dual_issue_case_b2_off,
      ctrl.dual_issue_case_b1_off, ctrl.dual_issue_case_a_off}
      == $past(cp_req.wdata[ACUB_DI_C_POS:ACUB_DI_A_POS]))
    else $error("dual issue bits not stored");

  b1_check_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.bside_bank1_check_en == $past(cp_req.wdata[ACUB_B1_CHK_POS]))
    else $error("bank1 check enable not stored");

  b0_check_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.bside_bank0_check_en == $past(cp_req.wdata[ACUB_B0_CHK_POS]))
    else $error("bank0 check enable not stored");

  a_check_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.aside_memory_check_en == $past(cp_req.wdata[ACUB_A_CHK_POS]))
    else $error("A memory check enable not stored");

  slave_en_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.slave_cache_ram_access_en == $past(cp_req.wdata[ACUB_SLV_EN_POS]))
    else $error("slave access enable not stored");

  user_en_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.slave_cache_ram_user_access_en == $past(cp_req.wdata[ACUB_SLV_USR_POS]))
    else $error("slave user access enable not stored");

  irq_off_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.low_latency_irq_multiple_off == $past(cp_req.wdata[ACUB_LLI_OFF_POS]))
    else $error("low latency disable not stored");

  loop_off_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.loop_end_prediction_off == $past(cp_req.wdata[ACUB_LOOP_OFF_POS]))
    else $error("loop prediction disable not stored");

  history_off_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.branch_history_ext_off == $past(cp_req.wdata[ACUB_BHE_OFF_POS]))
    else $error("history extension disable not stored");

  fetch_off_write_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> ctrl.fetch_rate_ctrl_off == $past(cp_req.wdata[ACUB_FRC_OFF_POS]))
    else $error("fetch rate disable not stored");

  // ---------------------------------------------------------------------------
  // Reset value checks
  // ---------------------------------------------------------------------------
  // After any reset cycle every fixed field shows its reset value.
  dual_issue_reset_a: assert property (@(posedge clk)
    $past(rst) |-> ctrl.dual_issue_case_b2_off == ACUB_OFF_RESET
      && ctrl.dual_issue_case_b1_off == ACUB_OFF_RESET
      && ctrl.dual_issue_case_a_off == ACUB_OFF_RESET)
    else $error("dual issue bit not zero after reset");

  irq_off_reset_a: assert property (@(posedge clk)
    $past(rst) |-> ctrl.low_latency_irq_multiple_off == ACUB_OFF_RESET)
    else $error("low latency disable not zero after reset");

  loop_off_reset_a: assert property (@(posedge clk)
    $past(rst) |-> ctrl.loop_end_prediction_off == ACUB_OFF_RESET)
    else $error("loop prediction disable not zero after reset");

  history_off_reset_a: assert property (@(posedge clk)
    $past(rst) |-> ctrl.branch_history_ext_off == ACUB_OFF_RESET)
    else $error("history extension disable not zero after reset");

  in_reset_zero_a: assert property (@(posedge clk)
    $past(rst) |-> ctrl == '0 && cp_rsp == '0 && !cmo_undef && !caches_off)
    else $error("outputs not cleared by reset");

  // ---------------------------------------------------------------------------
  // Access checks
  // ---------------------------------------------------------------------------
  // An answer comes exactly one cycle after a selected request outside the strap-load cycle, and only then.
  done_per_hit_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg.init_done && hit) |=> cp_rsp.done)
    else $error("selected access not answered");

  done_needs_hit_a: assert property (@(posedge clk) disable iff (rst)
    !(state_reg.init_done && hit) |=> !cp_rsp.done)
    else $error("answer without selected access");

  rdata_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !priv_rd |=> cp_rsp.rdata == 32'h0)
    else $error("read data outside privileged read");

  priv_no_undef_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg.init_done && hit && cp_req.privileged) |=> !cp_rsp.undef)
    else $error("privileged access refused");

  undef_needs_done_a: assert property (@(posedge clk) disable iff (rst)
    cp_rsp.undef |-> cp_rsp.done)
    else $error("refusal without answer");

  caches_follow_a: assert property (@(posedge clk) disable iff (rst)
    priv_wr |=> caches_off == $past(cp_req.wdata[ACUB_SLV_EN_POS]))
    else $error("caches off does not follow write");

  cmo_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !cmo_req |=> !cmo_undef)
    else $error("maintenance refusal without attempt");

  fields_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg.init_done && !priv_wr) |=> $stable(ctrl))
    else $error("fields changed without privileged write");

  init_once_a: assert property (@(posedge clk) disable iff (rst)
    state_reg.init_done |=> state_reg.init_done)
    else $error("strap load repeated");

endmodule

// >>> acub_core_model.sv
// Core-side model that issues privileged and unprivileged coprocessor accesses to the register.
`timescale 1ns/1ps
module acub_core_model
  import acub_pkg::*;
#(
  parameter bit ECC_BSIDE = 1'b0
)
(
  input wire logic clk,
  output acub_cp_req_t cp_req,
  input wire acub_cp_rsp_t cp_rsp
);
  initial begin
    cp_req = '0;
  end

  // One access: request held for one rising edge, answer taken at the next falling edge.
  task automatic access(input logic wr, input logic priv, input logic [3:0] crn,
      input logic [31:0] wd, output acub_cp_rsp_t rsp);
    logic [31:0] w;
    w = wd;
    if (ECC_BSIDE) begin
      w[26] = w[27];
    end
    @(negedge clk);
    cp_req.valid = 1'b1;
    cp_req.write = wr;
    cp_req.privileged = priv;
    cp_req.opc1 = ACUB_OPC1;
    cp_req.crn = crn;
    cp_req.crm = ACUB_CRM;
    cp_req.opc2 = ACUB_OPC2;
    cp_req.wdata = w;
    @(negedge clk);
    rsp = cp_rsp;
    cp_req.valid = 1'b0;
    // Released data shows the inverse so a stale value cannot pass.
    cp_req.wdata = ~w;
  endtask
endmodule

// >>> tb_top.sv
// Self-checking testbench for the auxiliary control upper bits.
`timescale 1ns/1ps
module tb_top;
  import acub_pkg::*;
  logic clk, rst, cmo_req, cmo_undef, caches_off;
  logic [2:0] cfg_in;
  acub_cp_req_t cp_req;
  acub_cp_rsp_t cp_rsp, r;
  acub_fields_t ctrl;
  int bad_count, n_tests;

  acub_aux_ctrl dut_u (.clk(clk), .rst(rst), .check_enable_config_in(cfg_in),
    .cp_req(cp_req), .cmo_req(cmo_req), .cp_rsp(cp_rsp), .cmo_undef(cmo_undef),
    .caches_off(caches_off), .ctrl(ctrl));
  acub_core_model core_u (.clk(clk), .cp_req(cp_req), .cp_rsp(cp_rsp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic t_reset;
    @(negedge clk);
    @(negedge clk);
    chk32("ctrl reset", {19'h0, 4'h0, cfg_in, 6'h0}, {19'h0, ctrl});
    core_u.access(1'b0, 1'b1, ACUB_CRN, 32'h0, r);
    chk1("done", 1'b1, r.done);
    chk32("rdata reset", {4'h0, cfg_in, 25'h0}, r.rdata);
    chk1("caches_off reset", 1'b0, caches_off);
  endtask

  task automatic t_walk;
    logic [31:0] w;
    for (int i = 19; i < 32; i++) begin
      w = 32'h1 << i;
      core_u.access(1'b1, 1'b1, ACUB_CRN, w | 32'h0007FFFF, r);
      chk1("write done", 1'b1, r.done);
      chk1("write undef", 1'b0, r.undef);
      chk32("ctrl", {19'h0, w[31:19]}, {19'h0, ctrl});
      core_u.access(1'b0, 1'b1, ACUB_CRN, 32'h0, r);
      chk32("rdata", w, r.rdata);
    end
    core_u.access(1'b1, 1'b1, ACUB_CRN, 32'h0, r);
  endtask

  task automatic t_unpriv;
    core_u.access(1'b1, 1'b0, ACUB_CRN, 32'hFFFFFFFF, r);
    chk1("unpriv undef", 1'b1, r.undef);
    chk32("ctrl kept", 32'h0, {19'h0, ctrl});
    core_u.access(1'b0, 1'b0, ACUB_CRN, 32'h0, r);
    chk1("unpriv rd done", 1'b1, r.done);
    chk32("unpriv rdata", 32'h0, r.rdata);
  endtask

  task automatic t_bad_sel;
    core_u.access(1'b1, 1'b1, 4'h2, 32'hFFFFFFFF, r);
    chk1("other sel done", 1'b0, r.done);
    chk32("ctrl untouched", 32'h0, {19'h0, ctrl});
  endtask

  task automatic cmo_pulse(input logic exp);
    @(negedge clk);
    cmo_req = 1'b1;
    @(negedge clk);
    cmo_req = 1'b0;
    chk1("cmo_undef", exp, cmo_undef);
  endtask

  task automatic t_slave;
    core_u.access(1'b1, 1'b1, ACUB_CRN, 32'h01000000, r);
    chk1("caches_off on", 1'b1, caches_off);
    cmo_pulse(1'b1);
    core_u.access(1'b1, 1'b1, ACUB_CRN, 32'h0, r);
    chk1("caches_off off", 1'b0, caches_off);
    cmo_pulse(1'b0);
  endtask

  task automatic t_restart;
    core_u.access(1'b1, 1'b1, ACUB_CRN, 32'hF1F80000, r);
    chk1("caches_off before reset", 1'b1, caches_off);
    @(negedge clk);
    rst = 1'b1;
    cfg_in = 3'b110;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk32("ctrl in reset", 32'h0, {19'h0, ctrl});
    chk1("caches_off in reset", 1'b0, caches_off);
    @(negedge clk);
    chk32("ctrl restart", {19'h0, 4'h0, 3'b110, 6'h0}, {19'h0, ctrl});
    core_u.access(1'b0, 1'b1, ACUB_CRN, 32'h0, r);
    chk32("rdata restart", {4'h0, 3'b110, 25'h0}, r.rdata);
  endtask

  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    cmo_req = 1'b0;
    cfg_in = 3'b101;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_walk();
    t_unpriv();
    t_bad_sel();
    t_slave();
    t_restart();
    wrap_up();
  end
endmodule
